// [hdl/vpw_bus_symbol_crc_codec.sv]
`timescale 1ns/1ps
`include "vpw_bus_symbol_crc_codec_regs.svh"

module vpw_bus_symbol_crc_codec (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire vpw_pkg::vpw_req_s req,
  output logic [31:0]           rdata,
  input  wire logic             rxLine,
  output logic                  txLine
);

  // ==========================================================
  // Functions
  function automatic logic [7:0] crcStep(input logic [7:0] crc, input logic bitIn);
    crcStep = {crc[6:0], 1'b0} ^ ((crc[7] ^ bitIn) ? `VPW_CRC_POLY : 8'h00);
  endfunction

  function automatic vpw_pkg::vpw_sym_e classify(input logic [9:0] dur, input logic active);
    if (dur < `VPW_BIT_MIN_US) begin
      classify = vpw_pkg::SYM_INV;
    end else if (dur < `VPW_BIT_SPLIT_US) begin
      classify = active ? vpw_pkg::SYM_ONE : vpw_pkg::SYM_ZERO;
    end else if (dur < `VPW_LONGSYM_US) begin
      classify = active ? vpw_pkg::SYM_ZERO : vpw_pkg::SYM_ONE;
    end else if (dur < `VPW_BREAK_US) begin
      classify = vpw_pkg::SYM_LONG;
    end else begin
      classify = vpw_pkg::SYM_EXT;
    end
  endfunction

  function automatic logic [7:0] bitLen(input logic bitVal, input logic level);
    bitLen = (bitVal ^ level) ? `VPW_LONG_US : `VPW_SHORT_US;
  endfunction

  // ==========================================================
  // Registers and state
  logic                  fourfold;
  logic [7:0]            prescale;
  logic [7:0]            preCnt;
  logic                  usTick;
  logic                  usTickD;
  logic [9:0]            usCnt;
  logic                  rxMeta;
  logic                  rxS;
  logic                  rxD;
  logic                  inFrame;
  logic                  frameSeen;
  logic [2:0]            rxBitCnt;
  logic [7:0]            rxShift;
  logic [7:0]            rxCrc;
  logic [7:0]            rxData;
  vpw_pkg::vpw_flags_s   flags;
  logic [7:0]            txBuf;
  logic                  txBufLast;
  logic                  txFull;
  vpw_pkg::vpw_tx_state_e txState;
  logic [7:0]            txTimer;
  logic [7:0]            txShift;
  logic [7:0]            txCrc;
  logic [2:0]            txBitCnt;
  logic                  txLast;
  logic                  crcSent;

  // ==========================================================
  // Bus decode
  wire wrCtrl   = req.wr && (req.addr == `VPW_OFF_CTRL);
  wire wrTx     = req.wr && (req.addr == `VPW_OFF_TXDATA);
  wire wrStatus = req.wr && (req.addr == `VPW_OFF_STATUS);
  wire rdRx     = req.rd && (req.addr == `VPW_OFF_RXDATA);
  wire [7:0] preLimit = fourfold ? {2'b00, prescale[7:2]} : prescale;

  // ==========================================================
  // Symbol timing
  // prescaled tick
  wire preWrap  = (preCnt + 8'h01) >= preLimit;
  wire rxEdge   = rxS != rxD;
  wire rxRise   = rxS && !rxD;
  wire passive  = !rxS && !rxEdge;
  wire activeLv = rxS && !rxEdge;
  wire busIdle  = passive && (usCnt > `VPW_IFS_US);
  wire [31:0] rdMux =
    (req.addr == `VPW_OFF_CTRL)   ? {16'h0000, prescale, 7'h00, fourfold} :
    (req.addr == `VPW_OFF_TXDATA) ? {31'h00000000, txFull} :
    (req.addr == `VPW_OFF_STATUS) ? {24'h000000, busIdle, txState == vpw_pkg::TX_IDLE,
                                     1'b0, flags} :
    (req.addr == `VPW_OFF_RXDATA) ? {24'h000000, rxData} : 32'h00000000;
  wire hitEod   = usTickD && (usCnt == `VPW_LONGSYM_US);
  wire hitEof   = usTickD && (usCnt == 10'(`VPW_EOF_US));
  wire hitBrk   = usTickD && (usCnt == `VPW_BREAK_US);

  wire vpw_pkg::vpw_sym_e sym = classify(usCnt, rxD);
  wire isBit    = (sym == vpw_pkg::SYM_ZERO) || (sym == vpw_pkg::SYM_ONE);
  wire rxBit    = sym == vpw_pkg::SYM_ONE;
  wire bitEv    = rxEdge && inFrame && isBit;
  wire sofEv    = rxEdge && rxD && (sym == vpw_pkg::SYM_LONG);
  wire invEv    = rxEdge && inFrame && (sym == vpw_pkg::SYM_INV);
  wire eodEv    = passive && hitEod && inFrame && (rxBitCnt == 3'h0);
  wire eofEv    = passive && hitEof && frameSeen;
  wire breakEv  = activeLv && hitBrk;
  wire rxBreak  = breakEv && inFrame;
  wire [7:0] rxShiftNext = {rxShift[6:0], rxBit};
  wire [7:0] rxCrcNext   = crcStep(rxCrc, rxBit);

  // ==========================================================
  // Transmit sequencing
  wire txLevel  = txBitCnt[0];
  wire txEnd    = usTick && (txTimer == 8'h01);
  wire txByteEnd = (txState == vpw_pkg::TX_DATA) && txEnd && (txBitCnt == 3'h7);
  wire [7:0] txCrcNext = crcStep(txCrc, txShift[7]);
  // start only when idle with a byte
  wire txStart  = (txState == vpw_pkg::TX_IDLE) && txFull && busIdle;
  wire loadCrc  = txByteEnd && !crcSent && txLast;
  wire loadBuf  = txStart || (txByteEnd && !crcSent && !txLast && txFull);
  wire underrun = txByteEnd && !crcSent && !txLast && !txFull;
  wire txBreak  = breakEv && (txState != vpw_pkg::TX_IDLE);

  // ==========================================================
  // Input synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      rxMeta <= 1'b0;
      rxS    <= 1'b0;
      rxD    <= 1'b0;
    end else begin
      rxMeta <= rxLine;
      rxS    <= rxMeta;
      rxD    <= rxS;
    end
  end

  // edges restart the tick and count
  always_ff @(posedge clock) begin
    if (rst || rxEdge) begin
      preCnt  <= 8'h00;
      usTick  <= 1'b0;
      usTickD <= 1'b0;
      usCnt   <= 10'h000;
    end else begin
      preCnt  <= preWrap ? 8'h00 : preCnt + 8'h01;
      usTick  <= preWrap;
      usTickD <= usTick;
      if (usTick && (usCnt != 10'h3FF)) begin
        usCnt <= usCnt + 10'h001;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      fourfold <= 1'b0;
      prescale <= `VPW_PRESCALE_RST;
    end else if (rxBreak && fourfold) begin
      fourfold <= 1'b0;
    end else if (wrCtrl) begin
      fourfold <= req.wdata[`VPW_CTRL_FOURFOLD];
      prescale <= req.wdata[`VPW_CTRL_PRE_MSB:`VPW_CTRL_PRE_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= req.rd ? rdMux : 32'h00000000;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      flags <= '0;
    end else begin
      if (wrStatus) begin
        flags <= flags & ~req.wdata[4:0];
      end
      if (rdRx) begin
        flags.rxValid <= 1'b0;
      end
      if (bitEv && (rxBitCnt == 3'h7)) begin
        flags.rxValid <= 1'b1;
      end
      if (eodEv && (rxCrc != `VPW_CRC_RESIDUE)) begin
        flags.crcErr <= 1'b1;
      end
      if (eofEv) begin
        flags.eof <= 1'b1;
      end
      if (rxBreak || invEv) begin
        flags.invSym <= 1'b1;
      end
      if (txBreak || underrun) begin
        flags.txErr <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Receiver
  always_ff @(posedge clock) begin
    if (rst) begin
      inFrame   <= 1'b0;
      frameSeen <= 1'b0;
      rxBitCnt  <= 3'h0;
      rxShift   <= 8'h00;
      rxCrc     <= `VPW_CRC_PRESET;
      rxData    <= 8'h00;
    end else if (sofEv) begin
      inFrame   <= 1'b1;
      frameSeen <= 1'b1;
      rxBitCnt  <= 3'h0;
      rxCrc     <= `VPW_CRC_PRESET;
    end else if (rxBreak || invEv) begin
      inFrame   <= 1'b0;
      frameSeen <= 1'b0;
    end else if (eofEv) begin
      inFrame   <= 1'b0;
      frameSeen <= 1'b0;
    end else if (bitEv) begin
      rxShift  <= rxShiftNext;
      rxCrc    <= rxCrcNext;
      rxBitCnt <= rxBitCnt + 3'h1;
      if (rxBitCnt == 3'h7) begin
        rxData <= rxShiftNext;
      end
    end
  end

  // ==========================================================
  // Transmitter
  always_ff @(posedge clock) begin
    if (rst) begin
      txBuf     <= 8'h00;
      txBufLast <= 1'b0;
      txFull    <= 1'b0;
    end else if (wrTx) begin
      txBuf     <= req.wdata[7:0];
      txBufLast <= req.wdata[`VPW_TX_LAST];
      txFull    <= 1'b1;
    end else if (loadBuf) begin
      txFull    <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txState  <= vpw_pkg::TX_IDLE;
      txTimer  <= 8'h00;
      txShift  <= 8'h00;
      txCrc    <= `VPW_CRC_PRESET;
      txBitCnt <= 3'h0;
      txLast   <= 1'b0;
      crcSent  <= 1'b0;
    end else if (txBreak || underrun) begin
      txState <= vpw_pkg::TX_IDLE;
    end else begin
      unique case (txState)
        vpw_pkg::TX_IDLE: begin
          if (txStart) begin
            txState <= vpw_pkg::TX_SOF;
            txTimer <= `VPW_SOF_US;
            txShift <= txBuf;
            txLast  <= txBufLast;
            txCrc   <= `VPW_CRC_PRESET;
            crcSent <= 1'b0;
          end
        end
        vpw_pkg::TX_SOF: begin
          if (txEnd) begin
            txState  <= vpw_pkg::TX_DATA;
            txBitCnt <= 3'h0;
            txTimer  <= bitLen(txShift[7], 1'b0);
          end else if (usTick) begin
            txTimer <= txTimer - 8'h01;
          end
        end
        vpw_pkg::TX_DATA: begin
          if (txEnd) begin
            txCrc    <= txCrcNext;
            txBitCnt <= txBitCnt + 3'h1;
            if (txByteEnd && crcSent) begin
              txState <= vpw_pkg::TX_IDLE;
            end else if (loadCrc) begin
              txShift <= ~txCrcNext;
              crcSent <= 1'b1;
              txTimer <= bitLen(~txCrcNext[7], 1'b0);
            end else if (loadBuf) begin
              txShift <= txBuf;
              txLast  <= txBufLast;
              txTimer <= bitLen(txBuf[7], 1'b0);
            end else begin
              txShift <= {txShift[6:0], 1'b0};
              txTimer <= bitLen(txShift[6], ~txLevel);
            end
          end else if (usTick) begin
            txTimer <= txTimer - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txLine <= 1'b0;
    end else begin
      txLine <= (txState == vpw_pkg::TX_SOF) ||
                ((txState == vpw_pkg::TX_DATA) && txLevel);
    end
  end

  // ==========================================================
  // Assertions
  property p_crcPreset;
    @(posedge clock) disable iff (rst) sofEv |=> (rxCrc == `VPW_CRC_PRESET) && inFrame;
  endproperty
  a_crcPreset: assert property (p_crcPreset) else $error("remainder not preset");

  property p_crcErr;
    @(posedge clock) disable iff (rst)
      (eodEv && (rxCrc != `VPW_CRC_RESIDUE)) |=> flags.crcErr;
  endproperty
  a_crcErr: assert property (p_crcErr) else $error("checksum error not flagged");

  property p_eodNoFlag;
    @(posedge clock) disable iff (rst)
      (eodEv && !eofEv && !wrStatus) |=> $stable(flags.eof);
  endproperty
  a_eodNoFlag: assert property (p_eodNoFlag) else $error("end of data changed flag");

  property p_eofFlag;
    @(posedge clock) disable iff (rst) eofEv |=> flags.eof && !inFrame;
  endproperty
  a_eofFlag: assert property (p_eofFlag) else $error("end of frame not flagged");

  property p_txBreak;
    @(posedge clock) disable iff (rst)
      txBreak |=> (txState == vpw_pkg::TX_IDLE) && flags.txErr ##1 !txLine;
  endproperty
  a_txBreak: assert property (p_txBreak) else $error("break did not halt transmit");

  property p_break4x;
    @(posedge clock) disable iff (rst)
      (rxBreak && fourfold) |=> !fourfold && flags.invSym && !inFrame;
  endproperty
  a_break4x: assert property (p_break4x) else $error("fourfold not cleared");

  property p_sofStart;
    @(posedge clock) disable iff (rst)
      txStart |=> (txState == vpw_pkg::TX_SOF) && (txTimer == `VPW_SOF_US) ##1 txLine;
  endproperty
  a_sofStart: assert property (p_sofStart) else $error("start symbol not driven");

  property p_firstPassive;
    @(posedge clock) disable iff (rst)
      ((txState == vpw_pkg::TX_SOF) && txEnd) |=> (txBitCnt == 3'h0) ##1 !txLine;
  endproperty
  a_firstPassive: assert property (p_firstPassive) else $error("byte not passive first");

  property p_crcAppend;
    @(posedge clock) disable iff (rst) loadCrc |=> txShift == ~$past(txCrcNext);
  endproperty
  a_crcAppend: assert property (p_crcAppend) else $error("check byte not inverted");

  property p_passiveIdle;
    @(posedge clock) disable iff (rst) $past(txState == vpw_pkg::TX_IDLE) |-> !txLine;
  endproperty
  a_passiveIdle: assert property (p_passiveIdle) else $error("line active while idle");

endmodule // vpw_bus_symbol_crc_codec

// [hdl/vpw_bus_symbol_crc_codec_regs.svh]
`ifndef VPW_BUS_SYMBOL_CRC_CODEC_REGS_SVH
`define VPW_BUS_SYMBOL_CRC_CODEC_REGS_SVH

// ==========================================================
// Register offsets
`define VPW_OFF_CTRL     4'h0
`define VPW_OFF_TXDATA   4'h4
`define VPW_OFF_STATUS   4'h8
`define VPW_OFF_RXDATA   4'hC

// ==========================================================
// Field positions
`define VPW_CTRL_FOURFOLD  0
`define VPW_CTRL_PRE_LSB   8
`define VPW_CTRL_PRE_MSB   15
`define VPW_TX_LAST        8

// ==========================================================
// Reset values and CRC constants
`define VPW_CLK_MHZ        100
`define VPW_PRESCALE_RST   8'(`VPW_CLK_MHZ)
`define VPW_CRC_PRESET     8'hFF
`define VPW_CRC_POLY       8'h1D
`define VPW_CRC_RESIDUE    8'hC4

// ==========================================================
// Symbol times in microsecond ticks
`define VPW_SHORT_US       8'h40
`define VPW_LONG_US        8'h80
`define VPW_SOF_US         8'hC8
`define VPW_BIT_MIN_US     10'h022
`define VPW_BIT_SPLIT_US   10'h060
`define VPW_LONGSYM_US     10'h0A3
`define VPW_EOD_NOM_US     10'h0C8
`define VPW_EOF_EXT_US     10'h050
`define VPW_EOF_US         (`VPW_EOD_NOM_US + `VPW_EOF_EXT_US)
`define VPW_BREAK_US       10'h0F0
`define VPW_IFS_US         10'h12C

`endif

// [hdl/vpw_pkg.sv]
package vpw_pkg;

  typedef enum logic [2:0] {
    SYM_INV,
    SYM_ZERO,
    SYM_ONE,
    SYM_LONG,
    SYM_EXT
  } vpw_sym_e;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SOF,
    TX_DATA
  } vpw_tx_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } vpw_req_s;

  typedef struct packed {
    logic txErr;
    logic invSym;
    logic crcErr;
    logic eof;
    logic rxValid;
  } vpw_flags_s;

endpackage

// [test/vpw_bus_node_model.sv]
`timescale 1ns/1ps

// ==========================================
// Remote node on the wired bus
module vpw_bus_node_model (
  input  wire logic clock,
  input  wire logic txLine,
  output wire logic rxLine
);
  logic       drive = 1'b0;
  int         tickClk = 4;
  logic [7:0] rxq[$];
  int         sofTicks = 0;
  int         lvlErr = 0;
  int         cnt = 0;
  int         nb = 0;
  logic       last = 1'b0;
  logic [7:0] sh = 8'h00;

  // Active level dominates, as on the real bus
  assign rxLine = txLine | drive;

  task automatic hold(input logic lvl, input int t);
    drive <= lvl;
    repeat (t * tickClk) @(posedge clock);
  endtask

  task automatic send(input logic [7:0] b[$], input int brk);
    logic lvl;
    lvl = 1'b0;
    hold(1'b1, 200);
    foreach (b[k]) begin
      if (k == brk) begin
        hold(1'b1, 300);
        break;
      end
      for (int i = 7; i >= 0; i--) begin
        hold(lvl, (b[k][i] == lvl) ? 64 : 128);
        lvl = ~lvl;
      end
    end
    drive <= 1'b0;
  endtask

  // Falling edge sampling keeps the decoder clear of the launch edge
  always @(negedge clock) begin
    if (txLine !== last) begin
      if (last && cnt / tickClk >= 163) begin
        sofTicks = cnt / tickClk;
        nb = 0;
      end else if (cnt / tickClk >= 34) begin
        if (nb == 0 && last) lvlErr++;
        sh = {sh[6:0], (cnt / tickClk < 96) ? last : ~last};
        nb++;
        if (nb == 8) begin
          rxq.push_back(sh);
          nb = 0;
        end
      end
      cnt = 1;
      last = txLine;
    end else begin
      cnt++;
    end
  end
endmodule // vpw_bus_node_model

// [test/vpw_bus_symbol_crc_codec_tb_top.sv]
`timescale 1ns/1ps
`include "vpw_bus_symbol_crc_codec_regs.svh"

module vpw_bus_symbol_crc_codec_tb_top;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  vpw_pkg::vpw_req_s req = '0;
  logic [31:0]       rdata;
  logic              rxLine;
  logic              txLine;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                t0;
  logic [31:0]       d;
  logic [7:0]        c;
  logic [7:0]        e[$];

  vpw_bus_symbol_crc_codec vpw_bus_symbol_crc_codec_i (
    .clock  (clock),
    .rst    (rst),
    .req    (req),
    .rdata  (rdata),
    .rxLine (rxLine),
    .txLine (txLine)
  );

  vpw_bus_node_model vpw_bus_node_model_i (
    .clock  (clock),
    .txLine (txLine),
    .rxLine (rxLine)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // Ceiling well above the expected run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] r = 8'hFF;
    foreach (b[k]) for (int i = 7; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ (((r[7] ^ b[k][i]) == 1'b1) ? 8'h1D : 8'h00);
    return ~r;
  endfunction

  task automatic regWr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    req <= {1'b1, 1'b0, a, v};
    @(posedge clock);
    req <= '0;
  endtask

  task automatic regRd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    req <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    req <= '0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chkin(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic idle(input int t);
    repeat (t * 4) @(posedge clock);
  endtask

  task automatic waitTx();
    for (int i = 0; i < 40000 && txLine !== 1'b1; i++) @(negedge clock);
    chk("tx started", 32'h1, txLine);
  endtask

  // Holding-buffer full is polled so bytes are never overwritten
  task automatic txb(input logic [31:0] v);
    logic [31:0] f;
    f = 32'h1;
    for (int i = 0; i < 5000 && f[0] !== 1'b0; i++) regRd(`VPW_OFF_TXDATA, f);
    chk("tx buffer free", 32'h0, f[0]);
    regWr(`VPW_OFF_TXDATA, v);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    regRd(`VPW_OFF_CTRL, d);
    chk("ctrl reset", 32'h0000_6400, d); // prescale default
    regRd(`VPW_OFF_STATUS, d);
    chk("flags reset", 32'h0, d[4:0]);
    chk("tx idle", 32'h1, d[6]);
    chk("tx line reset", 32'h0, txLine); // passive
    regRd(4'h2, d);
    chk("unmapped read", 32'h0, d);
    chk("rdata idle", 32'h0, rdata);
    regWr(`VPW_OFF_CTRL, 32'h0000_0400); // short ticks
    idle(330);
    regRd(`VPW_OFF_STATUS, d);
    chk("bus idle", 32'h1, d[7]); // idle bus
    $display("test reset done");

    c = crc8('{8'h3A});
    vpw_bus_node_model_i.send('{8'h3A, c}, -1);
    idle(190);
    regRd(`VPW_OFF_STATUS, d);
    chk("no flag at end of data", 32'h0, d[1]); // silent end of data
    chk("good crc", 32'h0, d[2]); // residue
    idle(100);
    regRd(`VPW_OFF_STATUS, d);
    chk("eof", 32'h1, d[1]); // end of frame
    chk("rx valid", 32'h1, d[0]);
    regRd(`VPW_OFF_RXDATA, d);
    chk("rx check byte", {24'h0, c}, d); // check byte kept
    regWr(`VPW_OFF_STATUS, 32'h1F);
    regRd(`VPW_OFF_STATUS, d);
    chk("flags cleared", 32'h0, d[4:0]);
    idle(30); // separation
    vpw_bus_node_model_i.send('{8'hC3, 8'h01, crc8('{8'hC3, 8'h01}) ^ 8'h80}, -1);
    idle(290);
    regRd(`VPW_OFF_STATUS, d);
    chk("bad crc", 32'h1, d[2]); // wrong residue
    regWr(`VPW_OFF_STATUS, 32'h1F);
    idle(30);
    $display("test receive done");

    vpw_bus_node_model_i.send('{8'h3A, crc8('{8'h3A})}, -1);
    t0 = cyc;
    regWr(`VPW_OFF_TXDATA, 32'h0A5);
    waitTx();
    chkin("gap before start", 300, 310, (cyc - t0) / 4); // wait
    regWr(`VPW_OFF_STATUS, 32'h1F);
    txb(32'h13C); // two data bytes
    idle(3700);
    e = '{8'hA5, 8'h3C, crc8('{8'hA5, 8'h3C})};
    chk("tx byte count", 32'd3, vpw_bus_node_model_i.rxq.size());
    foreach (e[k]) chk("tx byte", e[k], vpw_bus_node_model_i.rxq[k]);
    chkin("start length", 195, 205, vpw_bus_node_model_i.sofTicks); // start
    chk("byte start level", 32'h0, vpw_bus_node_model_i.lvlErr); // passive first
    regRd(`VPW_OFF_STATUS, d);
    chk("own frame crc", 32'h0, d[2]); // loopback
    chk("own frame eof", 32'h1, d[1]); // end
    chk("tx line after frame", 32'h0, txLine); // passive
    $display("test transmit done");

    regWr(`VPW_OFF_TXDATA, 32'h0FF);
    waitTx();
    txb(32'h1FF);
    idle(400);
    vpw_bus_node_model_i.hold(1'b1, 300);
    vpw_bus_node_model_i.hold(1'b0, 0);
    regRd(`VPW_OFF_STATUS, d);
    chk("tx error on break", 32'h1, d[4]); // halt on break
    repeat (400) begin
      @(negedge clock);
      chk("tx halted", 32'h0, txLine); // stays passive
    end
    regWr(`VPW_OFF_STATUS, 32'h1F);
    // Pending last byte goes out once the bus is idle again
    waitTx(); // separation before resend
    idle(2100);
    regWr(`VPW_OFF_TXDATA, 32'h011);
    waitTx();
    idle(1400);
    regRd(`VPW_OFF_STATUS, d);
    chk("underrun error", 32'h1, d[4]);
    chk("tx line after underrun", 32'h0, txLine); // passive
    $display("test transmit errors done");

    regWr(`VPW_OFF_STATUS, 32'h1F);
    regWr(`VPW_OFF_CTRL, 32'h0000_0401);
    vpw_bus_node_model_i.tickClk = 1;
    idle(320);
    vpw_bus_node_model_i.send('{8'h55, 8'h66}, 1);
    idle(10);
    regRd(`VPW_OFF_STATUS, d);
    chk("invalid symbol", 32'h1, d[3]); // break in frame
    regRd(`VPW_OFF_CTRL, d);
    chk("fourfold cleared", 32'h0000_0400, d); // fourfold off
    vpw_bus_node_model_i.tickClk = 4;
    $display("test fourfold break done");
    finish_test();
  end
endmodule // vpw_bus_symbol_crc_codec_tb_top
